// file: core/pmr_pkg.sv
// Package of constants and carrier types for the paged MAC register file
package pmr_pkg;

  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Page codes held in the page-select field of the command register
  localparam logic [1:0] PAGE_RUN    = 2'h0;
  localparam logic [1:0] PAGE_INIT   = 2'h1;
  localparam logic [1:0] PAGE_DIAG   = 2'h2;
  localparam logic [1:0] PAGE_LOCKED = 2'h3;

  // Command register field positions
  localparam int CMD_STOP_BIT   = 0;
  localparam int CMD_START_BIT  = 1;
  localparam int CMD_TXPKT_BIT  = 2;
  localparam int CMD_PAGE_LO    = 6;
  localparam int CMD_PAGE_HI    = 7;

  // Offsets shared by every page
  localparam logic [3:0] OFS_CMD           = 4'h0;
  // Run-time page, read side name first, write side in the comment; 0AH/0BH are named for the write side, read side in the comment
  localparam logic [3:0] OFS_RUN_LDMA_LO   = 4'h1; // ring page start
  localparam logic [3:0] OFS_RUN_LDMA_HI   = 4'h2; // ring page stop
  localparam logic [3:0] OFS_RUN_BOUNDARY  = 4'h3;
  localparam logic [3:0] OFS_RUN_TXSTAT    = 4'h4; // tx page start
  localparam logic [3:0] OFS_RUN_COLL      = 4'h5; // tx count low
  localparam logic [3:0] OFS_RUN_FIFO      = 4'h6; // tx count high
  localparam logic [3:0] OFS_RUN_INTSTAT   = 4'h7;
  localparam logic [3:0] OFS_RUN_RDMA_LO   = 4'h8; // remote start low
  localparam logic [3:0] OFS_RUN_RDMA_HI   = 4'h9; // remote start high
  localparam logic [3:0] OFS_RUN_RBC_LO    = 4'hA; // reserved on read
  localparam logic [3:0] OFS_RUN_RBC_HI    = 4'hB; // reserved on read
  localparam logic [3:0] OFS_RUN_RXSTAT    = 4'hC; // rx config
  localparam logic [3:0] OFS_RUN_FAE       = 4'hD; // tx config
  localparam logic [3:0] OFS_RUN_CRCE      = 4'hE; // data config
  localparam logic [3:0] OFS_RUN_MISS      = 4'hF; // interrupt mask
  // Initialization page
  localparam logic [3:0] OFS_INIT_STATION0 = 4'h1;
  localparam logic [3:0] OFS_INIT_STATION5 = 4'h6;
  localparam logic [3:0] OFS_INIT_CURRX    = 4'h7;
  localparam logic [3:0] OFS_INIT_MCAST0   = 4'h8;
  // Diagnostic page
  localparam logic [3:0] OFS_DIAG_RSTART   = 4'h1; // local DMA low
  localparam logic [3:0] OFS_DIAG_RSTOP    = 4'h2; // local DMA high
  localparam logic [3:0] OFS_DIAG_RNEXT    = 4'h3;
  localparam logic [3:0] OFS_DIAG_TXPAGE   = 4'h4;
  localparam logic [3:0] OFS_DIAG_LNEXT    = 4'h5;
  localparam logic [3:0] OFS_DIAG_ACNT_UP  = 4'h6;
  localparam logic [3:0] OFS_DIAG_ACNT_LO  = 4'h7;
  localparam logic [3:0] OFS_DIAG_RXCFG    = 4'hC;
  localparam logic [3:0] OFS_DIAG_TXCFG    = 4'hD;
  localparam logic [3:0] OFS_DIAG_DATACFG  = 4'hE;
  localparam logic [3:0] OFS_DIAG_INTMASK  = 4'hF;

  // Reset values
  localparam logic [7:0]  CMD_RESET  = 8'h01;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [7:0]  READ_ZERO  = 8'h00;
  localparam logic [14:0] PIN_IDLE   = 15'h7000;

  // Targets of a diagnostic-page load into the core's own counters
  typedef enum logic [2:0] {
    DIAG_LDMA_LO = 3'b000,
    DIAG_LDMA_HI = 3'b001,
    DIAG_RNEXT   = 3'b010,
    DIAG_LNEXT   = 3'b011,
    DIAG_ACNT_UP = 3'b100,
    DIAG_ACNT_LO = 3'b101
  } pmr_diag_e_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } pmr_state_t;

  // Host pins as sampled
  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic [3:0] addr;
    logic [7:0] data;
  } pmr_pins_t;

  // Software-written configuration seen by the core
  typedef struct packed {
    logic [7:0]      ringStart;
    logic [7:0]      ringStop;
    logic [7:0]      boundary;
    logic [7:0]      txPageStart;
    logic [7:0]      txCountLo;
    logic [7:0]      txCountHi;
    logic [7:0]      remoteStartLo;
    logic [7:0]      remoteStartHi;
    logic [7:0]      remoteCountLo;
    logic [7:0]      remoteCountHi;
    logic [7:0]      rxConfig;
    logic [7:0]      txConfig;
    logic [7:0]      dataConfig;
    logic [7:0]      intMask;
    logic [7:0]      currentRxPage;
    logic [5:0][7:0] stationAddr;
    logic [7:0][7:0] multicast;
  } pmr_cfg_t;

  // Live state owned by the core, shown on reads
  typedef struct packed {
    logic [15:0] localDma;
    logic [15:0] remoteDma;
    logic [7:0]  txStatus;
    logic [7:0]  collisions;
    logic [7:0]  fifoPeek;
    logic [7:0]  rxStatus;
    logic [7:0]  tallyFae;
    logic [7:0]  tallyCrc;
    logic [7:0]  tallyMiss;
    logic [7:0]  remoteNext;
    logic [7:0]  localNext;
    logic [15:0] addrCounter;
  } pmr_stat_t;

  typedef struct packed {
    logic        valid;
    pmr_diag_e_t target;
    logic [7:0]  data;
  } pmr_diag_t;

endpackage

// file: core/pmr_pin_sync.sv
// Two-stage synchroniser for the host pin bundle
`timescale 1ns/1ps
module pmr_pin_sync #(
  parameter int          W    = 15,
  parameter logic [14:0] INIT = 15'h7000
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Pins and synchronised copy
  input  wire logic [W-1:0] pinIn,
  output      logic [W-1:0] pinOut
);

  logic [W-1:0] stage1Q;

  // First stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage1Q <= INIT[W-1:0];
      pinOut  <= INIT[W-1:0];
    end
    else
    begin
      stage1Q <= pinIn;
      pinOut  <= stage1Q;
    end
  end

endmodule // pmr_pin_sync

// file: core/pmr_regs.sv
// Paged 8-bit register file reached through the host register port
//
// Operation
// - Every register is eight bits wide
// - Two command bits select one of four pages
// - Four address lines pick one of sixteen
// - Page zero splits read and write registers
// - 01H/02H read local DMA, write ring bounds
// - 04H-06H read status, write transmit setup
// - 08H/09H read remote address, write start
// - 0AH/0BH read reserved, write remote count
// - 0DH-0FH read tallies, write configuration
// - 0CH status/config; 00H,03H,07H read-write
// - Init page: station bytes, current receive page
// - Init page: eight multicast filter bytes
// - Diag page reads setup, writes local DMA
// - Diag page next pointers and address counter
`timescale 1ns/1ps
module pmr_regs (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Host register port
  input  wire logic                hostCsN,
  input  wire logic                hostRdN,
  input  wire logic                hostWrN,
  input  wire logic [3:0]          registerAddrLines,
  input  wire logic [7:0]          hostDataIn,
  output      logic [7:0]          hostDataOut,
  output      logic                hostDataOeN,
  // Core state and events
  input  wire pmr_pkg::pmr_stat_t  coreStat,
  input  wire logic [7:0]          intEvents,
  input  wire logic                txPktDone,
  // Register contents to the core
  output      pmr_pkg::pmr_cfg_t   cfg,
  output      logic [7:0]          commandReg,
  output      logic [7:0]          interruptStatus,
  output      pmr_pkg::pmr_diag_t  diagLoad
);

  pmr_pkg::pmr_pins_t  pinRaw;
  pmr_pkg::pmr_pins_t  pinSync;
  pmr_pkg::pmr_state_t stateQ;
  pmr_pkg::pmr_state_t stateD;
  pmr_pkg::pmr_cfg_t   cfgQ;
  pmr_pkg::pmr_diag_t  diagQ;
  logic [7:0]          commandQ;
  logic [7:0]          intStatusQ;
  logic [3:0]          accAddrQ;
  logic [7:0]          wrDataQ;
  logic [7:0]          dataOutQ;
  logic                dataOeNQ;
  logic [7:0]          rdVal;
  logic [1:0]          page;
  logic                rdAct;
  logic                wrAct;
  logic                writeFire;
  logic [2:0]          stationIdx;
  logic [2:0]          mcastIdx;

  assign pinRaw = '{csN: hostCsN, rdN: hostRdN, wrN: hostWrN,
                    addr: registerAddrLines, data: hostDataIn};

  // Host strobes are asynchronous to core_clk
  pmr_pin_sync #(
    .W    (15),
    .INIT (pmr_pkg::PIN_IDLE)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (pinRaw),
    .pinOut   (pinSync)
  );

  assign rdAct = !pinSync.csN && !pinSync.rdN;
  assign wrAct = !pinSync.csN && !pinSync.wrN;
  // Page bits are read live, so a page change takes effect at once
  assign page  = commandQ[pmr_pkg::CMD_PAGE_HI:pmr_pkg::CMD_PAGE_LO];
  // Commit on the trailing edge, when the data has surely settled
  assign writeFire = (stateQ == pmr_pkg::ST_WRITE) && !wrAct;
  assign stationIdx = 3'(accAddrQ - pmr_pkg::OFS_INIT_STATION0);
  assign mcastIdx   = 3'(accAddrQ - pmr_pkg::OFS_INIT_MCAST0);

  // Access sequencer
  always_comb
  begin
    stateD = stateQ;
    unique case (stateQ)
      pmr_pkg::ST_IDLE:
      begin
        if (rdAct)
          stateD = pmr_pkg::ST_READ;
        else if (wrAct)
          stateD = pmr_pkg::ST_WRITE;
      end
      pmr_pkg::ST_READ:
      begin
        if (!rdAct)
          stateD = pmr_pkg::ST_IDLE;
      end
      pmr_pkg::ST_WRITE:
      begin
        if (!wrAct)
          stateD = pmr_pkg::ST_IDLE;
      end
      default: stateD = pmr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      stateQ <= pmr_pkg::ST_IDLE;
    else
      stateQ <= stateD;
  end

  // Address taken at access start, data held until the write commits
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      accAddrQ <= 4'h0;
      wrDataQ  <= pmr_pkg::REG_RESET;
    end
    else
    begin
      if (stateQ == pmr_pkg::ST_IDLE)
        accAddrQ <= pinSync.addr;
      if (wrAct)
        wrDataQ <= pinSync.data;
    end
  end

  // Read decode; read and write sides of one offset differ by page
  always_comb
  begin
    rdVal = pmr_pkg::READ_ZERO;
    if (accAddrQ == pmr_pkg::OFS_CMD)
      rdVal = commandQ;
    else
    begin
      case (page)
        pmr_pkg::PAGE_RUN:
        begin
          case (accAddrQ)
            pmr_pkg::OFS_RUN_LDMA_LO:  rdVal = coreStat.localDma[7:0];
            pmr_pkg::OFS_RUN_LDMA_HI:  rdVal = coreStat.localDma[15:8];
            pmr_pkg::OFS_RUN_BOUNDARY: rdVal = cfgQ.boundary;
            pmr_pkg::OFS_RUN_TXSTAT:   rdVal = coreStat.txStatus;
            pmr_pkg::OFS_RUN_COLL:     rdVal = coreStat.collisions;
            pmr_pkg::OFS_RUN_FIFO:     rdVal = coreStat.fifoPeek;
            pmr_pkg::OFS_RUN_INTSTAT:  rdVal = intStatusQ;
            pmr_pkg::OFS_RUN_RDMA_LO:  rdVal = coreStat.remoteDma[7:0];
            pmr_pkg::OFS_RUN_RDMA_HI:  rdVal = coreStat.remoteDma[15:8];
            pmr_pkg::OFS_RUN_RXSTAT:   rdVal = coreStat.rxStatus;
            pmr_pkg::OFS_RUN_FAE:      rdVal = coreStat.tallyFae;
            pmr_pkg::OFS_RUN_CRCE:     rdVal = coreStat.tallyCrc;
            pmr_pkg::OFS_RUN_MISS:     rdVal = coreStat.tallyMiss;
            default:                   rdVal = pmr_pkg::READ_ZERO;
          endcase
        end
        pmr_pkg::PAGE_INIT:
        begin
          if (accAddrQ >= pmr_pkg::OFS_INIT_MCAST0)
            rdVal = cfgQ.multicast[mcastIdx];
          else if (accAddrQ == pmr_pkg::OFS_INIT_CURRX)
            rdVal = cfgQ.currentRxPage;
          else
            rdVal = cfgQ.stationAddr[stationIdx];
        end
        pmr_pkg::PAGE_DIAG:
        begin
          case (accAddrQ)
            pmr_pkg::OFS_DIAG_RSTART:  rdVal = cfgQ.ringStart;
            pmr_pkg::OFS_DIAG_RSTOP:   rdVal = cfgQ.ringStop;
            pmr_pkg::OFS_DIAG_RNEXT:   rdVal = coreStat.remoteNext;
            pmr_pkg::OFS_DIAG_TXPAGE:  rdVal = cfgQ.txPageStart;
            pmr_pkg::OFS_DIAG_LNEXT:   rdVal = coreStat.localNext;
            pmr_pkg::OFS_DIAG_ACNT_UP: rdVal = coreStat.addrCounter[15:8];
            pmr_pkg::OFS_DIAG_ACNT_LO: rdVal = coreStat.addrCounter[7:0];
            pmr_pkg::OFS_DIAG_RXCFG:   rdVal = cfgQ.rxConfig;
            pmr_pkg::OFS_DIAG_TXCFG:   rdVal = cfgQ.txConfig;
            pmr_pkg::OFS_DIAG_DATACFG: rdVal = cfgQ.dataConfig;
            pmr_pkg::OFS_DIAG_INTMASK: rdVal = cfgQ.intMask;
            default:                   rdVal = pmr_pkg::READ_ZERO;
          endcase
        end
        default: rdVal = pmr_pkg::READ_ZERO;
      endcase
    end
  end

  // Data bus driver, refreshed every cycle of a read
  // Zeroed on the edge that releases the bus, so no stale byte shows
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dataOutQ <= pmr_pkg::READ_ZERO;
      dataOeNQ <= 1'b1;
    end
    else
    begin
      dataOeNQ <= (stateD != pmr_pkg::ST_READ);
      if (stateQ == pmr_pkg::ST_READ && stateD == pmr_pkg::ST_READ)
        dataOutQ <= rdVal;
      else
        dataOutQ <= pmr_pkg::READ_ZERO;
    end
  end

  // Command: transmit bit set only by a written one, cleared by core
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      commandQ <= pmr_pkg::CMD_RESET;
    else
    begin
      if (txPktDone)
        commandQ[pmr_pkg::CMD_TXPKT_BIT] <= 1'b0;
      if (writeFire && accAddrQ == pmr_pkg::OFS_CMD)
      begin
        commandQ <= wrDataQ;
        // Writing zero to the transmit bit leaves it alone; set wins
        commandQ[pmr_pkg::CMD_TXPKT_BIT] <=
          wrDataQ[pmr_pkg::CMD_TXPKT_BIT] ||
          (commandQ[pmr_pkg::CMD_TXPKT_BIT] && !txPktDone);
      end
    end
  end

  // Interrupt status: hardware sets, host clears with ones, set wins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      intStatusQ <= pmr_pkg::REG_RESET;
    else if (writeFire && page == pmr_pkg::PAGE_RUN &&
             accAddrQ == pmr_pkg::OFS_RUN_INTSTAT)
      intStatusQ <= (intStatusQ & ~wrDataQ) | intEvents;
    else
      intStatusQ <= intStatusQ | intEvents;
  end

  // Software-written configuration
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cfgQ <= '0;
    else if (writeFire)
    begin
      case (page)
        pmr_pkg::PAGE_RUN:
        begin
          case (accAddrQ)
            pmr_pkg::OFS_RUN_LDMA_LO:  cfgQ.ringStart     <= wrDataQ;
            pmr_pkg::OFS_RUN_LDMA_HI:  cfgQ.ringStop      <= wrDataQ;
            pmr_pkg::OFS_RUN_BOUNDARY: cfgQ.boundary      <= wrDataQ;
            pmr_pkg::OFS_RUN_TXSTAT:   cfgQ.txPageStart   <= wrDataQ;
            pmr_pkg::OFS_RUN_COLL:     cfgQ.txCountLo     <= wrDataQ;
            pmr_pkg::OFS_RUN_FIFO:     cfgQ.txCountHi     <= wrDataQ;
            pmr_pkg::OFS_RUN_RDMA_LO:  cfgQ.remoteStartLo <= wrDataQ;
            pmr_pkg::OFS_RUN_RDMA_HI:  cfgQ.remoteStartHi <= wrDataQ;
            pmr_pkg::OFS_RUN_RBC_LO:   cfgQ.remoteCountLo <= wrDataQ;
            pmr_pkg::OFS_RUN_RBC_HI:   cfgQ.remoteCountHi <= wrDataQ;
            pmr_pkg::OFS_RUN_RXSTAT:   cfgQ.rxConfig      <= wrDataQ;
            pmr_pkg::OFS_RUN_FAE:      cfgQ.txConfig      <= wrDataQ;
            pmr_pkg::OFS_RUN_CRCE:     cfgQ.dataConfig    <= wrDataQ;
            pmr_pkg::OFS_RUN_MISS:     cfgQ.intMask       <= wrDataQ;
            default: ;
          endcase
        end
        pmr_pkg::PAGE_INIT:
        begin
          if (accAddrQ >= pmr_pkg::OFS_INIT_MCAST0)
            cfgQ.multicast[mcastIdx] <= wrDataQ;
          else if (accAddrQ == pmr_pkg::OFS_INIT_CURRX)
            cfgQ.currentRxPage <= wrDataQ;
          else if (accAddrQ != pmr_pkg::OFS_CMD)
            cfgQ.stationAddr[stationIdx] <= wrDataQ;
        end
        // Diag page writes go to the core; locked page is ignored
        default: ;
      endcase
    end
  end

  // Diagnostic loads into core-owned pointers, one-cycle pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      diagQ <= '0;
    else
    begin
      diagQ.valid <= 1'b0;
      diagQ.data  <= wrDataQ;
      if (writeFire && page == pmr_pkg::PAGE_DIAG)
      begin
        case (accAddrQ)
          pmr_pkg::OFS_DIAG_RSTART:
          begin
            diagQ.valid  <= 1'b1;
            diagQ.target <= pmr_pkg::DIAG_LDMA_LO;
          end
          pmr_pkg::OFS_DIAG_RSTOP:
          begin
            diagQ.valid  <= 1'b1;
            diagQ.target <= pmr_pkg::DIAG_LDMA_HI;
          end
          pmr_pkg::OFS_DIAG_RNEXT:
          begin
            diagQ.valid  <= 1'b1;
            diagQ.target <= pmr_pkg::DIAG_RNEXT;
          end
          pmr_pkg::OFS_DIAG_LNEXT:
          begin
            diagQ.valid  <= 1'b1;
            diagQ.target <= pmr_pkg::DIAG_LNEXT;
          end
          pmr_pkg::OFS_DIAG_ACNT_UP:
          begin
            diagQ.valid  <= 1'b1;
            diagQ.target <= pmr_pkg::DIAG_ACNT_UP;
          end
          pmr_pkg::OFS_DIAG_ACNT_LO:
          begin
            diagQ.valid  <= 1'b1;
            diagQ.target <= pmr_pkg::DIAG_ACNT_LO;
          end
          default: ;
        endcase
      end
    end
  end

  assign hostDataOut     = dataOutQ;
  assign hostDataOeN     = dataOeNQ;
  assign cfg             = cfgQ;
  assign commandReg      = commandQ;
  assign interruptStatus = intStatusQ;
  assign diagLoad        = diagQ;

endmodule // pmr_regs

// file: sim/pmr_regs_asserts.sv
// Concurrent checks on the paged register port and its core outputs
`timescale 1ns/1ps
module pmr_regs_asserts (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rst_n,
  // Host register port
  input wire logic               hostCsN,
  input wire logic               hostRdN,
  input wire logic               hostWrN,
  input wire logic [3:0]         registerAddrLines,
  input wire logic [7:0]         hostDataIn,
  input wire logic [7:0]         hostDataOut,
  input wire logic               hostDataOeN,
  // Core side
  input wire pmr_pkg::pmr_stat_t coreStat,
  input wire logic [7:0]         intEvents,
  input wire logic               txPktDone,
  input wire pmr_pkg::pmr_cfg_t  cfg,
  input wire logic [7:0]         commandReg,
  input wire logic [7:0]         interruptStatus,
  input wire pmr_pkg::pmr_diag_t diagLoad
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Six idle samples outlast both sync stages and the commit edge
  sequence s_cs_idle;
    hostCsN [*6];
  endsequence
  sequence s_rd_off;
    hostRdN [*5];
  endsequence

  property p_reset_vals;
    $rose(rst_n) |-> hostDataOeN && commandReg == pmr_pkg::CMD_RESET
      && interruptStatus == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");
  property p_out_zero;
    hostDataOeN |-> hostDataOut == 8'h00;
  endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("read data while not driving");
  property p_oe_cause;
    $fell(hostDataOeN) |-> !$past(hostRdN, 2) && !$past(hostCsN, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("bus driven without a read");
  property p_oe_release;
    s_rd_off |-> hostDataOeN;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("bus still driven after read ended");
  property p_diag_once;
    diagLoad.valid |=> !diagLoad.valid;
  endproperty
  a_diag_once: assert property (p_diag_once)
    else $error("diagnostic load longer than one cycle");
  property p_diag_cause;
    diagLoad.valid |-> commandReg[7:6] == pmr_pkg::PAGE_DIAG && hostWrN;
  endproperty
  a_diag_cause: assert property (p_diag_cause)
    else $error("diagnostic load outside page two");
  property p_ints_set;
    |intEvents |=> (interruptStatus & $past(intEvents)) == $past(intEvents);
  endproperty
  a_ints_set: assert property (p_ints_set)
    else $error("interrupt event not latched");
  property p_txp_clear;
    s_cs_idle ##0 txPktDone |=> !commandReg[pmr_pkg::CMD_TXPKT_BIT];
  endproperty
  a_txp_clear: assert property (p_txp_clear)
    else $error("transmit bit not cleared");
  property p_cfg_hold;
    s_cs_idle |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed with no write");
endmodule // pmr_regs_asserts

bind pmr_regs pmr_regs_asserts pmr_regs_asserts_inst (
  .core_clk, .rst_n, .hostCsN, .hostRdN, .hostWrN, .registerAddrLines,
  .hostDataIn, .hostDataOut, .hostDataOeN, .coreStat, .intEvents,
  .txPktDone, .cfg, .commandReg, .interruptStatus, .diagLoad
);

// file: sim/pmr_host_model.sv
// Host processor model driving the asynchronous register port
`timescale 1ns/1ps
module pmr_host_model (
  // Clock
  input wire logic        core_clk,
  // Strobes and address
  output logic            hostCsN,
  output logic            hostRdN,
  output logic            hostWrN,
  output logic [3:0]      registerAddrLines,
  // Data
  output logic [7:0]      hostDataIn,
  input wire logic [7:0]  hostDataOut,
  input wire logic        hostDataOeN
);
  logic [1:0] pageSel;

  initial
  begin
    hostCsN = 1'h1;
    hostRdN = 1'h1;
    hostWrN = 1'h1;
    registerAddrLines = 4'h0;
    hostDataIn = 8'h00;
    pageSel = 2'h0;
  end

  // Strobes held four samples, idle four, to clear the sync stages
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (pageSel == pmr_pkg::PAGE_LOCKED && a != 4'h0)
      return;
    if (a == 4'h0)
      pageSel = d[7:6];
    @(posedge core_clk);
    registerAddrLines <= a;
    hostDataIn <= d;
    hostCsN <= 1'h0;
    hostWrN <= 1'h0;
    repeat (4) @(posedge core_clk);
    hostCsN <= 1'h1;
    hostWrN <= 1'h1;
    hostDataIn <= ~d;
    repeat (4) @(posedge core_clk);
  endtask

  // No answer within the bound leaves unknown data for the caller
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    d = 8'hxx;
    n = 0;
    @(posedge core_clk);
    registerAddrLines <= a;
    hostCsN <= 1'h0;
    hostRdN <= 1'h0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hostDataOeN !== 1'h0 && n < 20);
    repeat (2) @(posedge core_clk);
    if (n < 20)
      d = hostDataOut;
    hostCsN <= 1'h1;
    hostRdN <= 1'h1;
    repeat (5) @(posedge core_clk);
  endtask
endmodule // pmr_host_model

// file: sim/tb.sv
// Self-checking bench for the paged register file
`timescale 1ns/1ps
module tb;
  logic               core_clk;
  logic               rst_n;
  logic               hostCsN;
  logic               hostRdN;
  logic               hostWrN;
  logic [3:0]         registerAddrLines;
  logic [7:0]         hostDataIn;
  logic [7:0]         hostDataOut;
  logic               hostDataOeN;
  pmr_pkg::pmr_stat_t coreStat;
  logic [7:0]         intEvents;
  logic               txPktDone;
  pmr_pkg::pmr_cfg_t  cfg;
  logic [7:0]         commandReg;
  logic [7:0]         interruptStatus;
  pmr_pkg::pmr_diag_t diagLoad;
  pmr_pkg::pmr_diag_t dq[$];
  int                 errTotal;
  int                 checkCount;
  int                 cycles;
  localparam logic [3:0] DIAG_ADDR [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
  localparam pmr_pkg::pmr_diag_e_t DIAG_TGT [6] = '{pmr_pkg::DIAG_LDMA_LO,
    pmr_pkg::DIAG_LDMA_HI, pmr_pkg::DIAG_RNEXT, pmr_pkg::DIAG_LNEXT,
    pmr_pkg::DIAG_ACNT_UP, pmr_pkg::DIAG_ACNT_LO};

  initial
  begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  pmr_regs pmr_regs_inst (.core_clk, .rst_n, .hostCsN, .hostRdN, .hostWrN,
    .registerAddrLines, .hostDataIn, .hostDataOut, .hostDataOeN, .coreStat,
    .intEvents, .txPktDone, .cfg, .commandReg, .interruptStatus, .diagLoad);
  pmr_host_model pmr_host_model_inst (.core_clk, .hostCsN, .hostRdN,
    .hostWrN, .registerAddrLines, .hostDataIn, .hostDataOut, .hostDataOeN);

  always @(posedge core_clk)
    if (diagLoad.valid === 1'h1)
      dq.push_back(diagLoad);

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    pmr_host_model_inst.rd(a, d);
    chk8(d, exp);
  endtask

  function automatic logic [7:0] expRun(input logic [3:0] a);
    case (a)
      4'h1: return coreStat.localDma[7:0];
      4'h2: return coreStat.localDma[15:8];
      4'h3: return 8'h13;
      4'h4: return coreStat.txStatus;
      4'h5: return coreStat.collisions;
      4'h6: return coreStat.fifoPeek;
      4'h8: return coreStat.remoteDma[7:0];
      4'h9: return coreStat.remoteDma[15:8];
      4'hC: return coreStat.rxStatus;
      4'hD: return coreStat.tallyFae;
      4'hE: return coreStat.tallyCrc;
      4'hF: return coreStat.tallyMiss;
      default: return 8'h00;
    endcase
  endfunction

  // Page two reads of 01H, 02H, 04H and 0CH-0FH come from the page zero writes made earlier
  function automatic logic [7:0] expDiag(input logic [3:0] a);
    case (a)
      4'h1, 4'h2, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: return 8'h10 + 8'(a);
      4'h3: return coreStat.remoteNext;
      4'h5: return coreStat.localNext;
      4'h6: return coreStat.addrCounter[15:8];
      4'h7: return coreStat.addrCounter[7:0];
      default: return 8'h00;
    endcase
  endfunction

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", errTotal, checkCount);
    if (errTotal == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run needs about 1050 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errTotal++;
      conclude();
    end
  end

  initial
  begin
    rst_n = 1'h0;
    intEvents = 8'h00;
    txPktDone = 1'h0;
    coreStat = {16'h1A2B, 16'h3C4D, 8'h51, 8'h62, 8'h73, 8'h84, 8'h95,
                8'hA6, 8'hB7, 8'hC8, 8'hD9, 16'hE0F1};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    chk8(commandReg, pmr_pkg::CMD_RESET);
    chk8(interruptStatus, 8'h00);
    for (int a = 1; a < 16; a++)
      if (a != 7)
        pmr_host_model_inst.wr(4'(a), 8'h10 + 8'(a));
    chk8(cfg.ringStart, 8'h11);
    chk8(cfg.ringStop, 8'h12);
    chk8(cfg.txPageStart, 8'h14);
    chk8(cfg.txCountLo, 8'h15);
    chk8(cfg.txCountHi, 8'h16);
    chk8(cfg.remoteStartLo, 8'h18);
    chk8(cfg.remoteStartHi, 8'h19);
    chk8(cfg.remoteCountLo, 8'h1A);
    chk8(cfg.remoteCountHi, 8'h1B);
    chk8(cfg.rxConfig, 8'h1C);
    chk8(cfg.txConfig, 8'h1D);
    chk8(cfg.dataConfig, 8'h1E);
    chk8(cfg.intMask, 8'h1F);
    for (int a = 1; a < 16; a++)
      if (a != 7)
        rdChk(4'(a), expRun(4'(a)));
    @(posedge core_clk);
    intEvents <= 8'h05;
    @(posedge core_clk);
    intEvents <= 8'h00;
    rdChk(4'h7, 8'h05);
    pmr_host_model_inst.wr(4'h7, 8'h01);
    rdChk(4'h7, 8'h04);
    pmr_host_model_inst.wr(4'h0, 8'h05);
    chk8(commandReg, 8'h05);
    pmr_host_model_inst.wr(4'h0, 8'h01);
    chk8(commandReg, 8'h05);
    repeat (3) @(posedge core_clk);
    txPktDone <= 1'h1;
    @(posedge core_clk);
    txPktDone <= 1'h0;
    @(posedge core_clk);
    chk8(commandReg, 8'h01);
    pmr_host_model_inst.wr(4'h0, 8'h41);
    rdChk(4'h0, 8'h41);
    for (int a = 1; a < 16; a++)
      pmr_host_model_inst.wr(4'(a), 8'h40 + 8'(a));
    for (int a = 1; a < 16; a++)
      rdChk(4'(a), 8'h40 + 8'(a));
    pmr_host_model_inst.wr(4'h0, 8'h81);
    for (int a = 1; a < 16; a++)
      pmr_host_model_inst.wr(4'(a), 8'h60 + 8'(a));
    chk8(8'(dq.size()), 8'h06);
    foreach (DIAG_ADDR[i])
      if (i < dq.size())
      begin
        chk8(dq[i].data, 8'h60 + 8'(DIAG_ADDR[i]));
        chk8(8'(dq[i].target), 8'(DIAG_TGT[i]));
      end
    for (int a = 1; a < 16; a++)
      rdChk(4'(a), expDiag(4'(a)));
    pmr_host_model_inst.wr(4'h0, 8'hC1);
    rdChk(4'h9, 8'h00);
    rdChk(4'h0, 8'hC1);
    conclude();
  end
endmodule // tb
